// file: include/gpe_pkg.sv
// Purpose: Shared constants and helpers for the port-5 and external
//          interrupt block.
// Assumes: Registers sit at full 32-bit byte addresses on AXI4-Lite.
// Notes:   Register reset values are kept here only; debounce field positions are also hard-coded in gpe_top.
`default_nettype none
package gpe_pkg;
    localparam logic [31:0] ADDR_CFG  = 32'hFFF83050;
    localparam logic [31:0] ADDR_DIR  = 32'hFFF83054;
    localparam logic [31:0] ADDR_OUT  = 32'hFFF83058;
    localparam logic [31:0] ADDR_IN   = 32'hFFF8305C;
    localparam logic [31:0] ADDR_DBN  = 32'hFFF83070;
    localparam logic [31:0] ADDR_XCFG = 32'hFFF83074;
    localparam logic [31:0] ADDR_STAT = 32'hFFF83078;
    localparam logic [31:0] ADDR_MASK = 32'hFFF8307C;

    localparam int NPIN  = 13;
    localparam int NLINE = 4;
    localparam int DIV_W = 7;

    localparam int DBN_SEL_LSB = 4;
    localparam int DBN_EN_LSB  = 0;
    localparam int XC_C_EN     = 7;
    localparam int XC_C_FLT    = 6;
    localparam int XC_C_TYPE   = 4;
    localparam int XC_B_EN     = 3;
    localparam int XC_B_FLT    = 2;
    localparam int XC_B_TYPE   = 0;
    localparam int PIN16_IDX   = 11;
    localparam int PIN17_IDX   = 12;

    localparam logic [1:0] FUNC_GPIO  = 2'h0;
    localparam logic [1:0] TRIG_LOW   = 2'h0;
    localparam logic [1:0] TRIG_HIGH  = 2'h1;
    localparam logic [1:0] TRIG_FALL  = 2'h2;
    localparam logic [1:0] TRIG_RISE  = 2'h3;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [25:0] RST_CFG  = 26'h0000000;
    localparam logic [12:0] RST_DIR  = 13'h0000;
    localparam logic [12:0] RST_OUT  = 13'h0000;
    localparam logic [4:0]  RST_DBN  = 5'h00;
    localparam logic [7:0]  RST_XCFG = 8'h00;
    localparam logic [1:0]  RST_STAT = 2'h0;
    localparam logic [1:0]  RST_MASK = 2'h0;

    function automatic logic trig_hit(input logic [1:0] kind,
                                      input logic       cur,
                                      input logic       prev);
        unique case (kind)
            TRIG_LOW:  trig_hit = !cur;
            TRIG_HIGH: trig_hit = cur;
            TRIG_FALL: trig_hit = prev && !cur;
            TRIG_RISE: trig_hit = !prev && cur;
        endcase
    endfunction : trig_hit

    function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
        div_mask = DIV_W'((8'h01 << sel) - 8'h01);
    endfunction : div_mask
endpackage : gpe_pkg
`default_nettype wire

// file: include/gpe_filt_if.sv
// Purpose: Carrier between the register top and the shared debouncer.
// Assumes: One clock domain.
// Notes:   Line order is pin16, pin17, line b, line c.
`timescale 1ns/1ns
`default_nettype none
interface gpe_filt_if;
    logic       sample_tick;
    logic [3:0] raw;
    logic [3:0] filt_en;
    logic [3:0] level;
    modport ctrl (output sample_tick, output raw, output filt_en,
                  input level);
    modport filt (input sample_tick, input raw, input filt_en,
                  output level);
endinterface : gpe_filt_if
`default_nettype wire

// file: verilog/gpe_filter.sv
// Purpose: Synchroniser and debouncer for the four interrupt inputs.
// Assumes: sample_tick is a one-cycle pulse from the shared divider.
// Notes:   A filtered level moves only after two equal tick samples.
`timescale 1ns/1ns
`default_nettype none
module gpe_filter (
    input  wire logic  clock,
    input  wire logic  rst_n,
    gpe_filt_if.filt   fi
);
    logic [3:0] sy1_ff;
    logic [3:0] sy2_ff;
    logic [3:0] smp_ff;
    logic [3:0] lvl_ff;
    logic [3:0] nxt_smp;
    logic [3:0] nxt_lvl;

    // With its filter enabled, sample and level are updated only on a tick, so a pulse shorter
    // than one filter period never reaches the trigger logic.
    always_comb begin
        nxt_smp = smp_ff;
        nxt_lvl = lvl_ff;
        for (int k = 0; k < 4; k++) begin
            if (!fi.filt_en[k]) begin
                nxt_lvl[k] = sy2_ff[k];
            end else if (fi.sample_tick) begin
                nxt_smp[k] = sy2_ff[k];
                if (sy2_ff[k] == smp_ff[k]) begin
                    nxt_lvl[k] = sy2_ff[k];
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sy1_ff <= 4'hF;
            sy2_ff <= 4'hF;
            smp_ff <= 4'hF;
            lvl_ff <= 4'hF;
        end else begin
            sy1_ff <= fi.raw;
            sy2_ff <= sy1_ff;
            smp_ff <= nxt_smp;
            lvl_ff <= nxt_lvl;
        end
    end

    assign fi.level = lvl_ff;

    property p_filt_move;
        @(posedge clock) disable iff (!rst_n)
        (($past(fi.filt_en) & (lvl_ff ^ $past(lvl_ff))) != 4'h0)
            |-> $past(fi.sample_tick);
    endproperty
    a_filt_move: assert property (p_filt_move)
        else $error("Filtered level moved without a sample tick.");
endmodule : gpe_filter
`default_nettype wire

// file: verilog/gpe_top.sv
// Purpose: Port-5 data path, debounce control and two external interrupt
//          lines with sticky status, behind an AXI4-Lite slave.
// Assumes: Pin inputs are synchronous to clock; one write and one read
//          at most are outstanding.
// Notes:   Pin drive is registered, so pins follow registers one cycle
//          late.
// Behaviour
// - A GPIO output pin drives its bit of the output value field.
// - Writes to reserved output register bits change nothing.
// - Input value field shows every pin level regardless of mode.
// - Reserved input value bits read as zero.
// - Debounce sample clock is bus clock divided by two to the select.
// - Debounce control bits 1 and 0 filter pin 17 and pin 16.
// - Line b events are accepted only while config bit 3 is set.
// - Enabled requests of lines b and c are ORed onto channel 31.
// - Config bit 6 routes line c through the shared debouncer.
// - Config bit 2 routes line b through the shared debouncer.
// - Status bit 1 marks line c trigger, bit 0 marks line b trigger.
// - Status bits stay set until software clears them.
// - Drive enable counts only when the pin function is GPIO.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module gpe_top (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [12:0] port_pin_in,
    output logic [12:0]      port_pin_out,
    output logic [12:0]      port_pin_oe,
    input  wire logic [12:0] alt_func_out,
    input  wire logic [12:0] alt_func_oe,
    input  wire logic        ext_interrupt_line_b_n,
    input  wire logic        ext_interrupt_line_c_n,
    output logic             line_a0_level,
    output logic             line_a1_level,
    output logic             irq_ch31
);
    logic [25:0] cfg_ff;
    logic [12:0] dir_ff;
    logic [12:0] out_ff;
    logic [4:0]  dbn_ff;
    logic [7:0]  xcfg_ff;
    logic [1:0]  stat_ff;
    logic [1:0]  mask_ff;
    logic [25:0] nxt_cfg;
    logic [12:0] nxt_dir;
    logic [12:0] nxt_out;
    logic [4:0]  nxt_dbn;
    logic [7:0]  nxt_xcfg;
    logic [1:0]  nxt_stat;
    logic [1:0]  nxt_mask;

    logic        aw_got_ff;
    logic        w_got_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        nxt_aw_got;
    logic        nxt_w_got;
    logic [31:0] nxt_awaddr;
    logic [31:0] nxt_wdata;
    logic [3:0]  nxt_wstrb;
    logic        nxt_bvalid;
    logic [1:0]  nxt_bresp;
    logic        wr_do;
    logic [31:0] wr_word;

    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        nxt_rvalid;
    logic [31:0] nxt_rdata;
    logic [1:0]  nxt_rresp;

    logic [gpe_pkg::DIV_W-1:0] div_ff;
    logic [1:0]  prev_ff;
    logic [1:0]  event_hit;
    logic [12:0] pin_out_ff;
    logic [12:0] pin_oe_ff;
    logic [12:0] nxt_pin_out;
    logic [12:0] nxt_pin_oe;
    logic [12:0] gpio_sel;
    logic        irq_ff;
    logic        a0_ff;
    logic        a1_ff;

    gpe_filt_if fbus ();

    gpe_filter u_filter (
        .clock (clock),
        .rst_n (rst_n),
        .fi    (fbus.filt)
    );

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = strb[b] ? data[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : merge

    // Write channel: address and data are taken in either order.
    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_w_got  = w_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_wdata  = wdata_ff;
        nxt_wstrb  = wstrb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp  = bresp_ff;
        wr_do      = aw_got_ff && w_got_ff && !bvalid_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_got = 1'b1;
            nxt_wdata = s_axi_wdata;
            nxt_wstrb = s_axi_wstrb;
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (wr_do) begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_bvalid = 1'b1;
            unique case (awaddr_ff)
                gpe_pkg::ADDR_CFG, gpe_pkg::ADDR_DIR, gpe_pkg::ADDR_OUT,
                gpe_pkg::ADDR_IN, gpe_pkg::ADDR_DBN, gpe_pkg::ADDR_XCFG,
                gpe_pkg::ADDR_STAT, gpe_pkg::ADDR_MASK:
                    nxt_bresp = gpe_pkg::RESP_OKAY;
                default: nxt_bresp = gpe_pkg::RESP_SLVERR;
            endcase
        end
    end

    // Register file; the input value address takes writes as no-ops.
    always_comb begin
        nxt_cfg  = cfg_ff;
        nxt_dir  = dir_ff;
        nxt_out  = out_ff;
        nxt_dbn  = dbn_ff;
        nxt_xcfg = xcfg_ff;
        nxt_mask = mask_ff;
        nxt_stat = stat_ff;
        wr_word  = 32'h00000000;
        if (wr_do) begin
            unique case (awaddr_ff)
                gpe_pkg::ADDR_CFG: begin
                    wr_word = merge({6'h00, cfg_ff}, wdata_ff, wstrb_ff);
                    nxt_cfg = wr_word[25:0];
                end
                gpe_pkg::ADDR_DIR: begin
                    wr_word = merge({19'h0, dir_ff}, wdata_ff, wstrb_ff);
                    nxt_dir = wr_word[12:0];
                end
                gpe_pkg::ADDR_OUT: begin
                    wr_word = merge({19'h0, out_ff}, wdata_ff, wstrb_ff);
                    nxt_out = wr_word[12:0];
                end
                gpe_pkg::ADDR_DBN: begin
                    wr_word = merge({25'h0, dbn_ff[4:2], 2'h0, dbn_ff[1:0]},
                                    wdata_ff, wstrb_ff);
                    nxt_dbn = {wr_word[6:4], wr_word[1:0]};
                end
                gpe_pkg::ADDR_XCFG: begin
                    wr_word  = merge({24'h0, xcfg_ff}, wdata_ff, wstrb_ff);
                    nxt_xcfg = wr_word[7:0];
                end
                gpe_pkg::ADDR_MASK: begin
                    wr_word  = merge({30'h0, mask_ff}, wdata_ff, wstrb_ff);
                    nxt_mask = wr_word[1:0];
                end
                gpe_pkg::ADDR_STAT: begin
                    if (wstrb_ff[0]) begin
                        nxt_stat = stat_ff & ~wdata_ff[1:0];
                    end
                end
                default: wr_word = 32'h00000000;
            endcase
        end
        // A new event outranks a clear in the same cycle.
        nxt_stat = nxt_stat | event_hit;
    end

    // Read channel: one cycle from address to data.
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = gpe_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                gpe_pkg::ADDR_CFG:  nxt_rdata = {6'h00, cfg_ff};
                gpe_pkg::ADDR_DIR:  nxt_rdata = {19'h0, dir_ff};
                gpe_pkg::ADDR_OUT:  nxt_rdata = {19'h0, out_ff};
                gpe_pkg::ADDR_IN:   nxt_rdata = {19'h0, port_pin_in};
                gpe_pkg::ADDR_DBN:
                    nxt_rdata = {25'h0, dbn_ff[4:2], 2'h0, dbn_ff[1:0]};
                gpe_pkg::ADDR_XCFG: nxt_rdata = {24'h0, xcfg_ff};
                gpe_pkg::ADDR_STAT: nxt_rdata = {30'h0, stat_ff};
                gpe_pkg::ADDR_MASK: nxt_rdata = {30'h0, mask_ff};
                default: begin
                    nxt_rdata = 32'h00000000;
                    nxt_rresp = gpe_pkg::RESP_SLVERR;
                end
            endcase
        end
    end

    // Divider tick: every 2^select cycles, one cycle wide.
    assign fbus.sample_tick = (div_ff & gpe_pkg::div_mask(dbn_ff[4:2]))
                              == gpe_pkg::div_mask(dbn_ff[4:2]);
    assign fbus.raw     = {ext_interrupt_line_c_n, ext_interrupt_line_b_n,
                           port_pin_in[gpe_pkg::PIN17_IDX],
                           port_pin_in[gpe_pkg::PIN16_IDX]};
    assign fbus.filt_en = {xcfg_ff[gpe_pkg::XC_C_FLT],
                           xcfg_ff[gpe_pkg::XC_B_FLT],
                           dbn_ff[1:0]};

    // Level triggers fire every cycle they hold, so software must remove
    // the cause before its clear can stick.
    always_comb begin
        event_hit[0] = xcfg_ff[gpe_pkg::XC_B_EN] &&
            gpe_pkg::trig_hit(xcfg_ff[gpe_pkg::XC_B_TYPE +: 2],
                              fbus.level[2], prev_ff[0]);
        event_hit[1] = xcfg_ff[gpe_pkg::XC_C_EN] &&
            gpe_pkg::trig_hit(xcfg_ff[gpe_pkg::XC_C_TYPE +: 2],
                              fbus.level[3], prev_ff[1]);
    end

    always_comb begin
        for (int i = 0; i < gpe_pkg::NPIN; i++) begin
            gpio_sel[i] = cfg_ff[i*2 +: 2] == gpe_pkg::FUNC_GPIO;
            nxt_pin_out[i] = gpio_sel[i] ? out_ff[i] : alt_func_out[i];
            nxt_pin_oe[i]  = gpio_sel[i] ? dir_ff[i] : alt_func_oe[i];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff     <= gpe_pkg::RST_CFG;
            dir_ff     <= gpe_pkg::RST_DIR;
            out_ff     <= gpe_pkg::RST_OUT;
            dbn_ff     <= gpe_pkg::RST_DBN;
            xcfg_ff    <= gpe_pkg::RST_XCFG;
            stat_ff    <= gpe_pkg::RST_STAT;
            mask_ff    <= gpe_pkg::RST_MASK;
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            awaddr_ff  <= 32'h00000000;
            wdata_ff   <= 32'h00000000;
            wstrb_ff   <= 4'h0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= 2'h0;
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h00000000;
            rresp_ff   <= 2'h0;
            div_ff     <= '0;
            prev_ff    <= 2'h3;
            pin_out_ff <= 13'h0000;
            pin_oe_ff  <= 13'h0000;
            irq_ff     <= 1'b0;
            a0_ff      <= 1'b1;
            a1_ff      <= 1'b1;
        end else begin
            cfg_ff     <= nxt_cfg;
            dir_ff     <= nxt_dir;
            out_ff     <= nxt_out;
            dbn_ff     <= nxt_dbn;
            xcfg_ff    <= nxt_xcfg;
            stat_ff    <= nxt_stat;
            mask_ff    <= nxt_mask;
            aw_got_ff  <= nxt_aw_got;
            w_got_ff   <= nxt_w_got;
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            awready_ff <= !nxt_aw_got && !nxt_bvalid;
            wready_ff  <= !nxt_w_got && !nxt_bvalid;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            arready_ff <= !nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
            div_ff     <= div_ff + gpe_pkg::DIV_W'(1);
            prev_ff    <= fbus.level[3:2];
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff  <= nxt_pin_oe;
            irq_ff     <= |(stat_ff & mask_ff);
            a0_ff      <= fbus.level[0];
            a1_ff      <= fbus.level[1];
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign port_pin_out  = pin_out_ff;
    assign port_pin_oe   = pin_oe_ff;
    assign line_a0_level = a0_ff;
    assign line_a1_level = a1_ff;
    assign irq_ch31      = irq_ff;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_gpio_drive;
        1'b1 |=> ((pin_out_ff ^ $past(out_ff)) & $past(gpio_sel)) == 13'h0;
    endproperty
    a_gpio_drive: assert property (p_gpio_drive)
        else $error("GPIO pin does not follow the output value.");
    property p_out_hold;
        !(wr_do && awaddr_ff == gpe_pkg::ADDR_OUT) |=> $stable(out_ff);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("Output value changed without a write.");
    property p_rd_resv;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == gpe_pkg::ADDR_IN
            |=> s_axi_rdata[31:13] == 19'h0;
    endproperty
    a_rd_resv: assert property (p_rd_resv)
        else $error("Reserved read bits are not zero.");
    property p_tick_sel2;
        fbus.sample_tick && dbn_ff[4:2] == 3'h2 && !wr_do
            |=> !fbus.sample_tick [*3] ##1 fbus.sample_tick;
    endproperty
    a_tick_sel2: assert property (p_tick_sel2)
        else $error("Sample tick spacing wrong for select 2.");
    property p_c_disabled;
        !xcfg_ff[gpe_pkg::XC_C_EN] |=> !$rose(stat_ff[1]);
    endproperty
    a_c_disabled: assert property (p_c_disabled)
        else $error("Line c status set while disabled.");
    property p_b_disabled;
        !xcfg_ff[gpe_pkg::XC_B_EN] |=> !$rose(stat_ff[0]);
    endproperty
    a_b_disabled: assert property (p_b_disabled)
        else $error("Line b status set while disabled.");
    property p_irq_or;
        1'b1 |=> irq_ch31 == |($past(stat_ff) & $past(mask_ff));
    endproperty
    a_irq_or: assert property (p_irq_or)
        else $error("Channel 31 request disagrees with status and mask.");
    property p_b_event;
        xcfg_ff[gpe_pkg::XC_B_EN] && xcfg_ff[1:0] == gpe_pkg::TRIG_LOW
            && !fbus.level[2] |=> stat_ff[0];
    endproperty
    a_b_event: assert property (p_b_event)
        else $error("Line b low level did not set status.");
    property p_sticky;
        stat_ff[0] && !(wr_do && awaddr_ff == gpe_pkg::ADDR_STAT)
            |=> stat_ff[0];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("Status bit dropped without a clear.");
    property p_alt_oe;
        1'b1 |=> ((pin_oe_ff ^ $past(alt_func_oe)) & ~$past(gpio_sel))
                 == 13'h0;
    endproperty
    a_alt_oe: assert property (p_alt_oe)
        else $error("Alternate pin enable not honoured.");

    c_irq: cover property ($rose(irq_ch31));
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_line_c: cover property ($rose(stat_ff[1]));
endmodule : gpe_top
`default_nettype wire

// file: dv/gpe_pin_model.sv
// Purpose: Stand-in for the board wiring on the thirteen port-5 pins.
// Assumes: Pins without a drive enable are held by an outside source.
// Notes:   The level seen back is registered, like a pad input stage.
`timescale 1ns/1ns
`default_nettype none
module gpe_pin_model (
    input  wire logic        clock,
    input  wire logic [12:0] pin_out,
    input  wire logic [12:0] pin_oe,
    input  wire logic [12:0] ext_level,
    output logic [12:0]      pin_level
);
    initial pin_level = 13'h0000;
    // A driven pin reads back its own drive, so a fight never shows up.
    always @(posedge clock) begin
        pin_level <= (pin_out & pin_oe) | (ext_level & ~pin_oe);
    end
endmodule : gpe_pin_model
`default_nettype wire

// file: dv/tb_gpio_port5_ext_irq.sv
// Purpose: Self-checking bench for the port-5 and interrupt block.
// Assumes: One write or one read under way at a time.
// Notes:   Bus answers are compared with notes queued by the driver.
`timescale 1ns/1ns
`default_nettype none
module tb_gpio_port5_ext_irq;
    logic        clock = 1'h0, rst_n = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [12:0] port_pin_in, port_pin_out, port_pin_oe, d;
    logic [12:0] ext_level = 13'h0, alt_func_out = 13'h0;
    logic [12:0] alt_func_oe = 13'h0;
    logic        ext_interrupt_line_b_n = 1'h1, ext_interrupt_line_c_n = 1'h1;
    logic        line_a0_level, line_a1_level, irq_ch31, m;
    logic [3:0]  nib;
    int          failures = 0, samples_checked = 0, seed = 32'h46D9FBAD;
    logic [33:0] notes[$];

    gpe_top dut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_pin_in,
        .port_pin_out, .port_pin_oe, .alt_func_out, .alt_func_oe,
        .ext_interrupt_line_b_n, .ext_interrupt_line_c_n,
        .line_a0_level, .line_a1_level, .irq_ch31);
    gpe_pin_model pins (.clock, .pin_out(port_pin_out),
        .pin_oe(port_pin_oe), .ext_level, .pin_level(port_pin_in));

    initial begin
        forever #25 clock = ~clock;
    end

    task automatic check(input logic [33:0] s, input logic [33:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask : check

    task automatic finish_test;
        $display("compares %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    task automatic wr(input logic [31:0] a, input logic [31:0] v,
                      input logic [1:0] r = gpe_pkg::RESP_OKAY);
        notes.push_back({r, 32'h0});
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [33:0] e);
        notes.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        @(posedge clock);
    endtask : rd

    task automatic setl(input int l, input logic v);
        if (l == 1) ext_interrupt_line_c_n <= v;
        else ext_interrupt_line_b_n <= v;
    endtask : setl

    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask : hold

    // Each bus answer is paired with the oldest note from the driver.
    always @(posedge clock) begin
        if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0},
            notes.pop_front());
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata},
            notes.pop_front());
    end

    initial begin
        hold(30000);
        failures++;
        finish_test();
    end

    initial begin
        hold(12);
        rst_n <= 1'h1;
        hold(1);
        ext_level <= 13'($random(seed));
        wr(gpe_pkg::ADDR_DBN, 32'h23);
        hold(40);
        rd(gpe_pkg::ADDR_IN, {21'h0, ext_level});
        check(34'(line_a0_level), 34'(ext_level[11]));
        check(34'(line_a1_level), 34'(ext_level[12]));
        d = 13'($random(seed));
        wr(gpe_pkg::ADDR_OUT, {19'h7FFFF, d});
        wr(gpe_pkg::ADDR_DIR, 32'h1FFF);
        hold(3);
        check(34'(port_pin_out), 34'(d));
        check(34'(port_pin_oe), 34'h1FFF);
        rd(gpe_pkg::ADDR_OUT, {21'h0, d});
        rd(gpe_pkg::ADDR_IN, {21'h0, d});
        alt_func_out <= 13'h1FFF;
        wr(gpe_pkg::ADDR_CFG, 32'h1);
        hold(3);
        check(34'(port_pin_oe), 34'h1FFE);
        check(34'(port_pin_out), 34'({d[12:1], 1'b1}));
        rd(32'hFFF83060, {gpe_pkg::RESP_SLVERR, 32'h0});
        wr(32'hFFF83064, 32'h1, gpe_pkg::RESP_SLVERR);
        $display("pin tests done");
        // Every trigger code is tried enabled and disabled on both lines.
        for (int l = 0; l < 2; l++) begin
            for (int k = 0; k < 8; k++) begin
                nib = {k[2], k[1] ^ k[0], k[1:0]};
                m = k[0] ~^ k[1];
                setl(l, !k[0]);
                hold(40);
                wr(gpe_pkg::ADDR_MASK, {30'h0, m, m});
                wr(gpe_pkg::ADDR_XCFG, 32'(nib) << (4 * l));
                wr(gpe_pkg::ADDR_STAT, 32'h3);
                rd(gpe_pkg::ADDR_STAT, 34'h0);
                setl(l, k[0]);
                hold(40);
                setl(l, !k[0]);
                hold(40);
                rd(gpe_pkg::ADDR_STAT, 34'(k[2]) << l);
                check(34'(irq_ch31), 34'(k[2] & m));
                wr(gpe_pkg::ADDR_STAT, 32'h3);
                rd(gpe_pkg::ADDR_STAT, 34'h0);
                check(34'(irq_ch31), 34'h0);
            end
        end
        $display("interrupt tests done");
        finish_test();
    end
endmodule : tb_gpio_port5_ext_irq
`default_nettype wire
